// ==== core/rmc_cfg_entry.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmc_cfg_entry
	import rmc_pkg::*;
#(
	parameter logic [7:0] RESET_VAL = 8'h00, // content after reset
	parameter logic [7:0] WMASK     = 8'hff  // writable bits
) (
	input wire logic   ref_clk, // system clock
	input wire logic   rst,     // synchronous reset
	rmc_entry_if.entry port     // access from the register bank
);
	logic [7:0] value;
	logic [7:0] next_value;

	// masked write; reserved bits stay zero
	always_comb begin
		next_value = value;
		if (port.wrEn) begin
			next_value = port.wrData & WMASK;
		end
	end

	// storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			value <= RESET_VAL;
		end else begin
			value <= next_value;
		end
	end

	assign port.value = value;
	assign port.nextValue = next_value;
endmodule : rmc_cfg_entry
`default_nettype wire

// ==== core/rmc_config_regs.sv ====
// Notes on behaviour
// [R1] mode: high=1 packet; else low=1 buffer; else continuous
// [R2] low data-mode bit sits at bit 5, reset zero
// [R3] high data-mode bit sits at bit 2, reset zero
// [R4] OOK threshold type bits 4-3: fixed, peak, average, reserved
// [R5] IF gain bits 1-0: 0, -4.5, -9, -13.5 dB
// [R6] data and modulation register resets to 0x88
// [R7] deviation is crystal/32 times value plus one
// [R8] deviation register resets to 0x03
// [R9] bit rate is crystal/64 divided by seven-bit value plus one
// [R10] bit rate register resets to 0x07
// [R11] host keeps bit rate top bit zero; it is reserved
// [R12] floor threshold counts 0.5 dB per step
// [R13] floor threshold register resets to 0x0c
// [R14] reads return last written value; settings apply at write completion
// [R15] fixed mode slices against floor; floor bounds peak and average
`timescale 1ns/1ps
`default_nettype none
module rmc_config_regs
	import rmc_pkg::*;
#(
	parameter int ADDR_W = 8 // byte address width
) (
	input  wire logic              ref_clk,           // 100 MHz clock
	input  wire logic              rst,               // sync reset, high
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,      // write address
	input  wire logic [2:0]        s_axi_awprot,      // unused
	input  wire logic              s_axi_awvalid,     // write address valid
	output logic                   s_axi_awready,     // write address ready
	input  wire logic [31:0]       s_axi_wdata,       // write data
	input  wire logic [3:0]        s_axi_wstrb,       // byte enables
	input  wire logic              s_axi_wvalid,      // write data valid
	output logic                   s_axi_wready,      // write data ready
	output logic [1:0]             s_axi_bresp,       // write response
	output logic                   s_axi_bvalid,      // response valid
	input  wire logic              s_axi_bready,      // response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,      // read address
	input  wire logic [2:0]        s_axi_arprot,      // unused
	input  wire logic              s_axi_arvalid,     // read address valid
	output logic                   s_axi_arready,     // read address ready
	output logic [31:0]            s_axi_rdata,       // read data
	output logic [1:0]             s_axi_rresp,       // read response
	output logic                   s_axi_rvalid,      // read data valid
	input  wire logic              s_axi_rready,      // read data ready
	input  wire logic [7:0]        rssiHalfDb,        // rssi, 0.5 dB steps
	input  wire logic              rssiValid,         // rssi sample strobe
	output logic [1:0]             modulationSelect,  // modulation select
	output logic [1:0]             dataMode,          // decoded data mode
	output logic [1:0]             ookThresholdType,  // threshold type
	output logic [1:0]             ifChainGain,       // IF gain code
	output logic [4:0]             ifAttenHalfDb,     // IF attenuation, 0.5 dB
	output logic [7:0]             deviationValue,    // deviation value
	output logic [8:0]             deviationMult,     // deviation / (xtal/32)
	output logic [6:0]             bitrateValue,      // bit rate value
	output logic [13:0]            bitPeriodXtal,     // xtal cycles per bit
	output logic [7:0]             floorThresholdValue, // floor, 0.5 dB
	output logic                   ookData            // sliced OOK data
);
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
		$error("ADDR_W must lie in 5..32");
	end

	// ---- bus state
	logic              awHeld, wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [7:0]        wData;
	logic              wLane0;
	logic              next_awHeld, next_wHeld, next_wLane0;
	logic [ADDR_W-1:0] next_awAddr;
	logic [7:0]        next_wData;
	logic              next_awready, next_wready, next_bvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic              next_arready, next_rvalid;
	logic [31:0]       next_rdata;
	logic              doWrite, wrHit;
	logic [RMC_IDX_W-1:0] wrIdx, rdIdx;
	logic [7:0]        cfg [1:4];
	logic [7:0]        cfgNext [1:4];
	logic [7:0]        rdByte;

	// register index of a byte address
	function automatic logic [RMC_IDX_W-1:0] idxOf(input logic [ADDR_W-1:0] a);
		idxOf = RMC_IDX_W'(a[ADDR_W-1:2]);
	endfunction

	// address falls on one of the four registers
	function automatic logic hitOf(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] w;
		w = a[ADDR_W-1:2];
		hitOf = (w >= (ADDR_W-2)'(RMC_IDX_FIRST)) && (w <= (ADDR_W-2)'(RMC_IDX_LAST));
	endfunction

	assign wrIdx = idxOf(awAddr);
	assign wrHit = hitOf(awAddr);
	assign rdIdx = idxOf(s_axi_araddr);
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	// read mux over the four registers
	always_comb begin
		rdByte = 8'h00;
		for (int i = RMC_IDX_FIRST; i <= RMC_IDX_LAST; i++) begin
			if (rdIdx == RMC_IDX_W'(i)) begin
				rdByte = cfg[i];
			end
		end
	end

	// bus next state: address and data taken in either order
	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wLane0 = wLane0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata[7:0];
			next_wLane0 = s_axi_wstrb[0];
		end
		if (doWrite) begin
			next_bvalid = 1'b1; // answer once the write has landed R14
			next_bresp = wrHit ? RMC_RESP_OKAY : RMC_RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
		end
		next_awready = !next_awHeld;
		next_wready = !next_wHeld;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = hitOf(s_axi_araddr) ? {24'h000000, rdByte} : 32'h00000000; // R14
			next_rresp = hitOf(s_axi_araddr) ? RMC_RESP_OKAY : RMC_RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid; // open whenever no read answer waits
	end

	// bus registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= 8'h00;
			wLane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RMC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RMC_RESP_OKAY;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wLane0 <= next_wLane0;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// one storage entry per register
	for (genvar g = RMC_IDX_FIRST; g <= RMC_IDX_LAST; g++) begin : g_reg
		rmc_entry_if u_if ();
		assign u_if.wrEn = doWrite && wrHit && wLane0 && (wrIdx == RMC_IDX_W'(g)); // R14
		assign u_if.wrData = wData;
		assign cfg[g] = u_if.value;
		assign cfgNext[g] = u_if.nextValue;
		rmc_cfg_entry #(
			.RESET_VAL (RMC_RESET_VAL[g]), // R6 R8 R10 R13
			.WMASK     (RMC_WMASK[g])      // R11
		) u_entry (
			.ref_clk (ref_clk),
			.rst     (rst),
			.port    (u_if.entry)
		);
	end

	// decoded settings, updated on the same edge as the register
	logic [1:0]  next_modulationSelect, next_dataMode, next_ookThresholdType;
	logic [1:0]  next_ifChainGain;
	logic [4:0]  next_ifAttenHalfDb;
	logic [7:0]  next_deviationValue, next_floorThresholdValue;
	logic [8:0]  next_deviationMult;
	logic [6:0]  next_bitrateValue;
	logic [13:0] next_bitPeriodXtal;
	logic [7:0]  dmNext;

	always_comb begin
		dmNext = cfgNext[RMC_IDX_DATA_MOD];
		next_modulationSelect = dmNext[RMC_MODULATION_SELECT_LSB +: 2];
		if (dmNext[RMC_DMH_BIT]) begin // R1 R3
			next_dataMode = RMC_DM_PKT;
		end else if (dmNext[RMC_DML_BIT]) begin // R1 R2
			next_dataMode = RMC_DM_BUF;
		end else begin
			next_dataMode = RMC_DM_CONT;
		end
		next_ookThresholdType = dmNext[RMC_OOKT_LSB +: 2]; // R4
		next_ifChainGain = dmNext[RMC_IFG_LSB +: 2]; // R5
		next_ifAttenHalfDb = 5'(next_ifChainGain) * RMC_IF_STEP_HALFDB; // R5
		next_deviationValue = cfgNext[RMC_IDX_DEVIATION];
		next_deviationMult = 9'(next_deviationValue) + 9'h001; // R7
		next_bitrateValue = cfgNext[RMC_IDX_BITRATE][6:0];
		next_bitPeriodXtal = (14'(next_bitrateValue) + 14'h0001) << RMC_BR_SHIFT; // R9
		next_floorThresholdValue = cfgNext[RMC_IDX_FLOOR]; // R12
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			modulationSelect <= RMC_RESET_VAL[RMC_IDX_DATA_MOD][RMC_MODULATION_SELECT_LSB +: 2];
			dataMode <= RMC_DM_CONT;
			ookThresholdType <= RMC_RESET_VAL[RMC_IDX_DATA_MOD][RMC_OOKT_LSB +: 2];
			ifChainGain <= RMC_RESET_VAL[RMC_IDX_DATA_MOD][RMC_IFG_LSB +: 2];
			ifAttenHalfDb <= 5'h00;
			deviationValue <= RMC_RESET_VAL[RMC_IDX_DEVIATION];
			deviationMult <= 9'(RMC_RESET_VAL[RMC_IDX_DEVIATION]) + 9'h001;
			bitrateValue <= RMC_RESET_VAL[RMC_IDX_BITRATE][6:0];
			bitPeriodXtal <= (14'(RMC_RESET_VAL[RMC_IDX_BITRATE][6:0]) + 14'h0001)
				<< RMC_BR_SHIFT;
			floorThresholdValue <= RMC_RESET_VAL[RMC_IDX_FLOOR];
		end else begin
			modulationSelect <= next_modulationSelect;
			dataMode <= next_dataMode;
			ookThresholdType <= next_ookThresholdType;
			ifChainGain <= next_ifChainGain;
			ifAttenHalfDb <= next_ifAttenHalfDb;
			deviationValue <= next_deviationValue;
			deviationMult <= next_deviationMult;
			bitrateValue <= next_bitrateValue;
			bitPeriodXtal <= next_bitPeriodXtal;
			floorThresholdValue <= next_floorThresholdValue;
		end
	end

	// OOK slicer fed by the threshold settings
	rmc_ook_slicer u_slicer (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.rssi      (rssiHalfDb),
		.rssiValid (rssiValid),
		.ookType   (ookThresholdType),
		.floorThr  (floorThresholdValue), // R15
		.ookData   (ookData)
	);

	// ---- checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic wrDm;
	assign wrDm = doWrite && wrHit && wLane0 && (wrIdx == RMC_IDX_W'(RMC_IDX_DATA_MOD));

	property p_mode_decode;
		dataMode == (cfg[1][RMC_DMH_BIT] ? RMC_DM_PKT :
			(cfg[1][RMC_DML_BIT] ? RMC_DM_BUF : RMC_DM_CONT));
	endproperty
	a_mode_decode: assert property (p_mode_decode) else $error("data mode decode wrong"); // R1

	property p_low_bit;
		wrDm |=> (cfg[1][5] == $past(wData[5])) && (dataMode[0] == ($past(wData[5])
			&& !$past(wData[2])));
	endproperty
	a_low_bit: assert property (p_low_bit) else $error("low mode bit not at bit 5"); // R2

	property p_high_bit;
		wrDm ##0 wData[2] |=> cfg[1][2] && dataMode == RMC_DM_PKT;
	endproperty
	a_high_bit: assert property (p_high_bit) else $error("high mode bit not at bit 2"); // R3

	property p_ook_type;
		wrDm |=> ookThresholdType == $past(wData[4:3]);
	endproperty
	a_ook_type: assert property (p_ook_type) else $error("threshold type not bits 4-3"); // R4

	property p_if_gain;
		ifAttenHalfDb == 5'(ifChainGain) * 5'h09 && ifChainGain == cfg[1][1:0];
	endproperty
	a_if_gain: assert property (p_if_gain) else $error("IF attenuation wrong"); // R5

	property p_reset_dm;
		$fell(rst) |-> cfg[1] == 8'h88 && dataMode == RMC_DM_CONT && ifAttenHalfDb == 5'h00;
	endproperty
	a_reset_dm: assert property (disable iff (1'b0) p_reset_dm) else $error("dm reset"); // R6

	property p_deviation;
		deviationMult == 9'(deviationValue) + 9'h001 && deviationValue == cfg[2];
	endproperty
	a_deviation: assert property (p_deviation) else $error("deviation multiple wrong"); // R7

	property p_reset_dev;
		$fell(rst) |-> cfg[2] == 8'h03 && deviationMult == 9'h004;
	endproperty
	a_reset_dev: assert property (disable iff (1'b0) p_reset_dev) else $error("dev reset"); // R8

	property p_bitrate;
		bitPeriodXtal == 14'((15'(bitrateValue) + 15'h0001) * 15'h0040);
	endproperty
	a_bitrate: assert property (p_bitrate) else $error("bit period wrong"); // R9

	property p_reset_br;
		$fell(rst) |-> cfg[3] == 8'h07 && bitPeriodXtal == 14'h0200;
	endproperty
	a_reset_br: assert property (disable iff (1'b0) p_reset_br) else $error("br reset"); // R10

	property p_br_rsvd;
		!cfg[3][RMC_BR_RSVD_BIT];
	endproperty
	a_br_rsvd: assert property (p_br_rsvd) else $error("reserved bit rate bit set"); // R11

	property p_floor;
		floorThresholdValue == cfg[4];
	endproperty
	a_floor: assert property (p_floor) else $error("floor threshold mismatch"); // R12

	property p_reset_floor;
		$fell(rst) |-> cfg[4] == 8'h0c && floorThresholdValue == 8'h0c;
	endproperty
	a_reset_floor: assert property (disable iff (1'b0) p_reset_floor) else $error("fl reset"); // R13

	property p_readback;
		(s_axi_arvalid && s_axi_arready && hitOf(s_axi_araddr))
			|=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(rdByte)};
	endproperty
	a_readback: assert property (p_readback) else $error("read data wrong"); // R14

	property p_write_answer;
		(awHeld && wHeld && !s_axi_bvalid) |=> s_axi_bvalid ##0 (!wrHit || !wLane0
			|| cfg[wrIdx] == ($past(wData) & RMC_WMASK[wrIdx]));
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not applied"); // R14

	c_packet: cover property (wrDm ##1 dataMode == RMC_DM_PKT);
	c_buffer: cover property (wrDm ##1 dataMode == RMC_DM_BUF);
	c_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RMC_RESP_OKAY);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RMC_RESP_SLVERR);
endmodule : rmc_config_regs
`default_nettype wire

// ==== core/rmc_entry_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rmc_entry_if;
	logic       wrEn;      // write this entry
	logic [7:0] wrData;    // data to write
	logic [7:0] value;     // current content
	logic [7:0] nextValue; // content after this edge

	modport ctrl (output wrEn, output wrData, input value, input nextValue);
	modport entry (input wrEn, input wrData, output value, output nextValue);
endinterface : rmc_entry_if
`default_nettype wire

// ==== core/rmc_ook_slicer.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmc_ook_slicer
	import rmc_pkg::*;
#(
	parameter int AVG_SHIFT = 3,        // averaging time constant, 2^n samples
	parameter logic [7:0] PEAK_DROP = 8'h0c // slice level below the peak
) (
	input  wire logic       ref_clk,   // system clock
	input  wire logic       rst,       // synchronous reset
	input  wire logic [7:0] rssi,      // signal strength, 0.5 dB per count
	input  wire logic       rssiValid, // new rssi sample
	input  wire logic [1:0] ookType,   // threshold type
	input  wire logic [7:0] floorThr,  // floor threshold
	output logic            ookData    // sliced data
);
	if (AVG_SHIFT < 1 || AVG_SHIFT > 7) begin : g_chk
		$error("AVG_SHIFT must lie in 1..7");
	end

	logic [7:0] peak, avg, thr;
	logic [7:0] next_peak, next_avg;
	logic       next_ookData;

	// tracking of peak and mean, slice against the chosen level
	always_comb begin
		next_peak = peak;
		next_avg = avg;
		next_ookData = ookData;
		if (rssi >= peak) begin
			next_peak = rssi;
		end else begin
			next_peak = peak - 8'h01; // slow decay
		end
		if (rssi > avg) begin
			next_avg = avg + 8'((rssi - avg) >> AVG_SHIFT);
		end else begin
			next_avg = avg - 8'((avg - rssi) >> AVG_SHIFT);
		end
		case (rmc_ook_type_t'(ookType))
			RMC_OOK_PEAK: thr = (peak > PEAK_DROP) ? peak - PEAK_DROP : 8'h00;
			RMC_OOK_AVG: thr = avg;
			default: thr = floorThr; // fixed, reserved treated as fixed
		endcase
		if (thr < floorThr) begin
			thr = floorThr; // floor is the lower bound R15
		end
		if (!rssiValid) begin
			next_peak = peak;
			next_avg = avg;
		end else begin
			next_ookData = (rssi >= thr); // R15
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			peak <= 8'h00;
			avg <= 8'h00;
			ookData <= 1'b0;
		end else begin
			peak <= next_peak;
			avg <= next_avg;
			ookData <= next_ookData;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_fixed_slice;
		(rssiValid && ookType == RMC_OOK_FIXED) |=> (ookData == ($past(rssi) >= $past(floorThr)));
	endproperty
	a_fixed_slice: assert property (p_fixed_slice) else $error("fixed slice wrong"); // R15
	c_fixed_hit: cover property (rssiValid && ookType == RMC_OOK_FIXED ##1 ookData);
endmodule : rmc_ook_slicer
`default_nettype wire

// ==== core/rmc_pkg.sv ====
package rmc_pkg;
	// register indices; byte address is four times the index
	localparam int unsigned RMC_IDX_DATA_MOD = 1;
	localparam int unsigned RMC_IDX_DEVIATION = 2;
	localparam int unsigned RMC_IDX_BITRATE = 3;
	localparam int unsigned RMC_IDX_FLOOR = 4;
	localparam int unsigned RMC_IDX_FIRST = RMC_IDX_DATA_MOD;
	localparam int unsigned RMC_IDX_LAST = RMC_IDX_FLOOR;
	localparam int unsigned RMC_IDX_W = 3;
	localparam int unsigned RMC_REG_W = 8;

	// values after reset and writable bits, indexed by register index
	localparam logic [7:0] RMC_RESET_VAL [1:4] = '{8'h88, 8'h03, 8'h07, 8'h0c};
	localparam logic [7:0] RMC_WMASK [1:4] = '{8'hff, 8'hff, 8'h7f, 8'hff};

	// data and modulation configuration fields, and the reserved bit rate bit
	localparam int unsigned RMC_MODULATION_SELECT_LSB = 6;
	localparam int unsigned RMC_DML_BIT = 5;
	localparam int unsigned RMC_OOKT_LSB = 3;
	localparam int unsigned RMC_DMH_BIT = 2;
	localparam int unsigned RMC_IFG_LSB = 0;
	localparam int unsigned RMC_BR_RSVD_BIT = 7;

	// scaling of the settings
	localparam logic [4:0] RMC_IF_STEP_HALFDB = 5'h09; // 4.5 dB per step
	localparam int unsigned RMC_DEV_PRESCALE = 32;
	localparam int unsigned RMC_BR_PRESCALE = 64;
	localparam int unsigned RMC_BR_SHIFT = $clog2(RMC_BR_PRESCALE);

	// data operation modes
	typedef enum logic [1:0] {
		RMC_DM_CONT = 2'h0,
		RMC_DM_BUF  = 2'h1,
		RMC_DM_PKT  = 2'h2
	} rmc_data_mode_t;

	// OOK threshold types
	typedef enum logic [1:0] {
		RMC_OOK_FIXED = 2'h0,
		RMC_OOK_PEAK  = 2'h1,
		RMC_OOK_AVG   = 2'h2,
		RMC_OOK_RSVD  = 2'h3
	} rmc_ook_type_t;

	// AXI responses
	localparam logic [1:0] RMC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RMC_RESP_SLVERR = 2'h2;
endpackage : rmc_pkg

// ==== verif/radio_modulation_config_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module radio_modulation_config_regs_test
	import rmc_pkg::*;
;
	logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, rssiValid, ookData, stalled;
	logic [7:0]  awaddr, araddr, rssiHalfDb, devVal, floorVal, f;
	logic [31:0] wdata, rdata, r;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, modulation_select, dataMode, ookType, if_chain_gain, eW;
	logic [4:0]  ifAtten;
	logic [8:0]  devMult;
	logic [6:0]  bitrate_value, b;
	logic [13:0] bitPeriod;
	logic [33:0] eR;
	logic [33:0] rdQ[$];
	logic [1:0]  wrQ[$];
	logic [31:0] seed = 32'h000159ed;
	int          mismatches, samples_checked;
	localparam logic [7:0] RV [1:4] = '{8'h88, 8'h03, 8'h07, 8'h0c};

	// free running clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	rmc_config_regs #(.ADDR_W(8)) dut (.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rssiHalfDb(rssiHalfDb), .rssiValid(rssiValid),
		.modulationSelect(modulation_select), .dataMode(dataMode), .ookThresholdType(ookType),
		.ifChainGain(if_chain_gain), .ifAttenHalfDb(ifAtten), .deviationValue(devVal),
		.deviationMult(devMult), .bitrateValue(bitrate_value), .bitPeriodXtal(bitPeriod),
		.floorThresholdValue(floorVal), .ookData(ookData));

	rmc_host_model host (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
		.stalled(stalled));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// take the oldest note whenever an answer is handed over
	always @(posedge ref_clk) begin
		if (rvalid && rready) begin
			eR = rdQ.pop_front();
			check("rdata", rdata, eR[31:0]);
			check("rresp", {30'h0, rresp}, {30'h0, eR[33:32]});
		end
		if (bvalid && bready) begin
			eW = wrQ.pop_front();
			check("bresp", {30'h0, bresp}, {30'h0, eW});
		end
	end

	// hang guards
	always @(posedge stalled) begin
		mismatches++;
		finish_test();
	end
	initial begin
		#500000;
		mismatches++;
		finish_test();
	end

	task automatic wr(input int idx, input logic [7:0] d, input logic [1:0] resp);
		wrQ.push_back(resp);
		host.write(8'(idx * 4), {24'h0, d}, 4'hf);
	endtask : wr

	task automatic rd(input int idx, input logic [7:0] d, input logic [1:0] resp);
		rdQ.push_back({resp, 24'h0, d});
		host.read(8'(idx * 4));
	endtask : rd

	// one rssi sample, then the sliced bit one edge later
	task automatic sample(input logic [7:0] v, input logic exp);
		@(posedge ref_clk);
		rssiHalfDb <= v;
		rssiValid  <= 1'b1;
		@(posedge ref_clk);
		rssiValid <= 1'b0;
		@(negedge ref_clk);
		check("ookData", {31'h0, ookData}, {31'h0, exp});
	endtask : sample

	// reset, then settings and registers at their reset values
	task automatic do_reset();
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		check("dataMode", {30'h0, dataMode}, 32'h0);
		check("ifAtten", {27'h0, ifAtten}, 32'h0);
		check("devMult", {23'h0, devMult}, 32'h4);
		check("bitPeriod", {18'h0, bitPeriod}, 32'h200);
		check("floor", {24'h0, floorVal}, 32'h0c);
		check("ookData", {31'h0, ookData}, 32'h0);
		for (int i = 1; i <= 4; i++) rd(i, RV[i], RMC_RESP_OKAY);
	endtask : do_reset

	initial begin
		rst        = 1'b1;
		rssiHalfDb = 8'h00;
		rssiValid  = 1'b0;
		do_reset();
		// every mode, threshold type and gain code
		for (int i = 0; i < 4; i++) begin
			b = 7'(i);
			wr(1, {~b[1:0], b[0], b[1:0], b[1], ~b[1:0]}, RMC_RESP_OKAY);
			check("dataMode", {30'h0, dataMode}, b[1] ? 32'h2 : {31'h0, b[0]});
			check("ookType", {30'h0, ookType}, {30'h0, b[1:0]});
			check("if_chain_gain", {30'h0, if_chain_gain}, {30'h0, ~b[1:0]});
			check("ifAtten", {27'h0, ifAtten}, 32'(9 * (3 - i)));
			check("modulation_select", {30'h0, modulation_select}, {30'h0, ~b[1:0]});
			rd(1, {~b[1:0], b[0], b[1:0], b[1], ~b[1:0]}, RMC_RESP_OKAY);
		end
		// deviation and bit rate at their bounds and at random, floor at random with bit 0 set
		wr(1, 8'h80, RMC_RESP_OKAY);
		for (int k = 0; k < 5; k++) begin
			r = rnd();
			f = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : r[7:0];
			b = f[6:0];
			wr(2, f, RMC_RESP_OKAY);
			check("devMult", {23'h0, devMult}, 32'(f) + 32'h1);
			check("devVal", {24'h0, devVal}, {24'h0, f});
			rd(2, f, RMC_RESP_OKAY);
			wr(3, {1'b0, b}, RMC_RESP_OKAY);
			check("bitPeriod", {18'h0, bitPeriod}, 32'h40 * (32'(b) + 32'h1));
			check("bitrate_value", {25'h0, bitrate_value}, {25'h0, b});
			rd(3, {1'b0, b}, RMC_RESP_OKAY);
			f = r[15:8] | 8'h01;
			wr(4, f, RMC_RESP_OKAY);
			check("floor", {24'h0, floorVal}, {24'h0, f});
			sample(f, 1'b1);
			sample(f - 8'h01, 1'b0);
			// peak or average type: floor still bounds the slice level
			wr(1, k[0] ? 8'h88 : 8'h90, RMC_RESP_OKAY);
			sample(8'hff, 1'b1);
			sample(f - 8'h01, 1'b0);
			wr(1, 8'h80, RMC_RESP_OKAY);
		end
		// unmapped places and a write with no byte enabled
		wr(0, 8'h5a, RMC_RESP_SLVERR);
		rd(5, 8'h00, RMC_RESP_SLVERR);
		wrQ.push_back(RMC_RESP_OKAY);
		host.write(8'h08, 32'h0000005a, 4'h0);
		rd(2, r[7:0], RMC_RESP_OKAY);
		do_reset();
		repeat (4) @(posedge ref_clk);
		check("pending", rdQ.size() + wrQ.size(), 32'h0);
		finish_test();
	end
endmodule : radio_modulation_config_regs_test
`default_nettype wire

// ==== verif/rmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model
	import rmc_pkg::*;
(
	input  wire logic        ref_clk, // clock
	output var logic [7:0]   awaddr,  // write address
	output var logic         awvalid, // write address valid
	input  wire logic        awready, // write address ready
	output var logic [31:0]  wdata,   // write data
	output var logic [3:0]   wstrb,   // byte enables
	output var logic         wvalid,  // write data valid
	input  wire logic        wready,  // write data ready
	input  wire logic        bvalid,  // response valid
	output var logic         bready,  // response ready
	output var logic [7:0]   araddr,  // read address
	output var logic         arvalid, // read address valid
	input  wire logic        arready, // read address ready
	input  wire logic        rvalid,  // read data valid
	output var logic         rready,  // read data ready
	output var logic         stalled  // an answer never came
);
	// bus idle at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, stalled} = '0;
	end

	// one write; each channel is released at its own handshake
	task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		if (a == 8'(RMC_IDX_BITRATE * 4)) d[7] = 1'b0;
		@(posedge ref_clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		bready <= 1'b0;
		if (n >= 200) stalled <= 1'b1;
	endtask : write

	// one read; rready held until rvalid is seen
	task automatic read(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
		end while (!rvalid && n < 200);
		rready <= 1'b0;
		if (n >= 200) stalled <= 1'b1;
	endtask : read
endmodule : rmc_host_model
`default_nettype wire
